// >>> src/homseq_core.sv
// Homing sequencer: drives a motion command through a homing profile.
// Assumes a position loop follows the dir/speed/run outputs and that
// pins are asynchronous; position counts arrive as step pulses.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "homseq_regs.svh"

module homseq_core (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic homing_start_cmd_i,
    input wire logic home_limit_switch_i,
    input wire logic positive_overtravel_i,
    input wire logic negative_overtravel_i,
    input wire logic index_pulse_i,
    input wire logic external_input_i,
    input wire logic preset_cmd_i,
    input wire logic pos_step_i,
    input wire logic pos_dir_i,
    input wire logic torque_at_limit_i,
    // Motion command
    output logic run_o,
    output logic dir_reverse_o,
    output logic [15:0] speed_o,
    output logic [6:0] torque_limit_o,
    output logic homing_complete_o,
    output logic homing_cancel_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] cfg_act, pretrav, shift_amt, coord, det_range;
    logic [31:0] cfg_live = `HS_CFG_RST; // Survives rst_i, as a stored setting
    logic [31:0] preset_val, int_amt, decel_time, stopper;
    logic [31:0] speeds, third_tl;
    logic signed [31:0] position, target;
    logic [31:0] moved, timer;
    logic homed, int_active;
    homseq_pkg::homseq_state_type state;

    // ------------------------------------------------------------
    // Pin synchronisers, two flops each
    // ------------------------------------------------------------
    localparam int NPIN = 10;
    logic [NPIN-1:0] pin_raw, sync1, sync2, sync_d;
    assign pin_raw = {torque_at_limit_i, pos_dir_i, pos_step_i,
        preset_cmd_i, external_input_i, index_pulse_i,
        negative_overtravel_i, positive_overtravel_i,
        home_limit_switch_i, homing_start_cmd_i};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync_d[gi] <= 1'b0;
                end else if (ce_i) begin
                    sync1[gi] <= pin_raw[gi];
                    sync2[gi] <= sync1[gi];
                    sync_d[gi] <= sync2[gi];
                end
            end
        end
    endgenerate
    wire start_rise = sync2[0] & ~sync_d[0];
    wire sw_lvl = sync2[1];
    wire pot = sync2[2];
    wire nott = sync2[3];
    wire idx_rise = sync2[4] & ~sync_d[4];
    wire ext_rise = sync2[5] & ~sync_d[5];
    wire preset_rise = sync2[6] & ~sync_d[6];
    wire step_rise = sync2[7] & ~sync_d[7];
    wire step_neg = sync2[8];
    wire torq_lim = sync2[9];

    // ------------------------------------------------------------
    // Active configuration decode
    // ------------------------------------------------------------
    wire [1:0] start_dir_sel = cfg_act[`HS_CFG_START_DIR];
    wire homing_dir_sel = cfg_act[`HS_CFG_HOME_DIR];
    wire [2:0] shift_ref_sel = cfg_act[`HS_CFG_SHIFT_REF];
    wire [1:0] decel_ref_sel = cfg_act[`HS_CFG_DECEL_REF];
    wire home_switch_edge_sel = cfg_act[`HS_CFG_EDGE];
    wire creep_reverse_en = cfg_act[`HS_CFG_CREEP_REV];
    wire ot_action_sel = cfg_act[`HS_CFG_OT_ACT];
    // Switch valid level chosen by edge select
    wire sw_valid = home_switch_edge_sel ? ~sw_lvl : sw_lvl;
    // Conditional start: head reverse if the switch already reads valid
    wire start_rev = (start_dir_sel == 2'd2) ? sw_valid
        : start_dir_sel[0];
    // Overtravel decel reference overrides homing direction
    wire home_rev = (decel_ref_sel == 2'd1) ? 1'b1
        : (decel_ref_sel == 2'd2) ? 1'b0 : homing_dir_sel;
    wire decel_hit = (decel_ref_sel == 2'd1) ? pot
        : (decel_ref_sel == 2'd2) ? nott : sw_valid;
    wire stop_hit = torq_lim && (timer >= stopper[15:0] * `HS_MS_CYCLES);
    wire shift_hit = (shift_ref_sel == 3'd0) ? sw_valid
        : (shift_ref_sel == 3'd2) ? pot
        : (shift_ref_sel == 3'd3) ? nott
        : (shift_ref_sel == 3'd4) ? ext_rise
        : (shift_ref_sel == 3'd5) ? stop_hit : 1'b0;
    wire index_mode = (shift_ref_sel == 3'd1);
    wire any_ref = decel_hit | shift_hit;
    wire moving = (state != homseq_pkg::HS_IDLE)
        && (state != homseq_pkg::HS_DONE)
        && (state != homseq_pkg::HS_CANCEL);
    wire ot_fault = ((pot & ~dir_reverse_o) | (nott & dir_reverse_o))
        && moving && state != homseq_pkg::HS_OT_DECEL
        && !(index_mode && decel_ref_sel != 2'd0)
        && shift_ref_sel != 3'd2 && shift_ref_sel != 3'd3;
    // Decel time in cycles, with decel_time counted in 0.1 ms steps
    wire [31:0] decel_cyc = 32'(decel_time * (`HS_MS_CYCLES / 10));
    wire signed [31:0] diff = position - coord;
    wire [31:0] abs_diff = diff[31] ? 32'(-diff) : 32'(diff);
    wire in_range = (det_range == 32'h0) || (abs_diff <= det_range);

    // ------------------------------------------------------------
    // Wishbone decode, one registered ack per request, a cycle after it
    // ------------------------------------------------------------
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_req & wb_we_i & (wb_sel_i == 4'hF);
    logic [31:0] rd_mux;
    always_comb begin
        unique case (wb_adr_i)
            `HS_CFG_OFF: rd_mux = cfg_live;
            `HS_PRETRAV_OFF: rd_mux = pretrav;
            `HS_SHIFT_OFF: rd_mux = shift_amt;
            `HS_COORD_OFF: rd_mux = coord;
            `HS_RANGE_OFF: rd_mux = det_range;
            `HS_PRESET_OFF: rd_mux = preset_val;
            `HS_INTAMT_OFF: rd_mux = int_amt;
            `HS_DECEL_OFF: rd_mux = decel_time;
            `HS_STOPPER_OFF: rd_mux = stopper;
            `HS_STATUS_OFF: rd_mux = {24'h0, homed, int_active,
                2'h0, 4'(state)};
            `HS_POS_OFF: rd_mux = position;
            `HS_SPEED_OFF: rd_mux = speeds;
            default: rd_mux = 32'h0;
        endcase
    end

    // Bus ack and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0;
        end
    end
    // Settings; cfg copies to the active set only at reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_act <= cfg_live;
            pretrav <= 32'h0;
            shift_amt <= `HS_SHIFT_RST;
            coord <= 32'h0;
            det_range <= 32'h0;
            preset_val <= 32'h0;
            int_amt <= `HS_INTAMT_RST;
            decel_time <= `HS_DECEL_RST;
            stopper <= 32'h0;
            speeds <= {`HS_CREEP_SPD_RST, `HS_HOMING_SPD_RST};
            third_tl <= 32'h0;
        end else if (ce_i && wb_wr) begin
            unique case (wb_adr_i)
                `HS_CFG_OFF: cfg_live <= wb_dat_i;
                `HS_PRETRAV_OFF: pretrav <= {1'b0, wb_dat_i[30:0]};
                `HS_SHIFT_OFF: shift_amt <= {1'b0, wb_dat_i[30:0]};
                `HS_COORD_OFF: coord <= wb_dat_i;
                `HS_RANGE_OFF: det_range <= {1'b0, wb_dat_i[30:0]};
                `HS_PRESET_OFF: preset_val <= wb_dat_i;
                `HS_INTAMT_OFF: int_amt <= wb_dat_i;
                `HS_DECEL_OFF: decel_time <= wb_dat_i;
                `HS_STOPPER_OFF: stopper <= wb_dat_i;
                `HS_SPEED_OFF: speeds <= wb_dat_i;
                `HS_CTRL_OFF: third_tl <= wb_dat_i;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= homseq_pkg::HS_IDLE;
            run_o <= 1'b0;
            dir_reverse_o <= 1'b0;
            speed_o <= 16'h0;
            torque_limit_o <= 7'h64;
            homing_cancel_o <= 1'b0;
            homed <= 1'b0;
            moved <= 32'h0;
            timer <= 32'h0;
            position <= 32'sh0;
            target <= 32'sh0;
            int_active <= 1'b0;
        end else if (ce_i) begin
            // Position follows the encoder step pulses
            if (step_rise)
                position <= step_neg ? position - 1 : position + 1;
            if (step_rise && moving)
                moved <= moved + 32'h1;
            timer <= (torq_lim || state == homseq_pkg::HS_OT_DECEL)
                ? timer + 32'h1 : 32'h0;
            // Interrupt positioning runs outside homing
            if (!moving && ext_rise && shift_ref_sel != 3'd4) begin
                int_active <= 1'b1;
                target <= position + int_amt;
                run_o <= 1'b1;
                speed_o <= speeds[15:0];
            end else if (int_active && position == target) begin
                int_active <= 1'b0;
                run_o <= 1'b0;
            end
            if (preset_rise && !moving)
                position <= preset_val;
            unique case (state)
                homseq_pkg::HS_IDLE, homseq_pkg::HS_DONE,
                homseq_pkg::HS_CANCEL: begin
                    if (start_rise && !int_active) begin
                        homed <= 1'b0;
                        homing_cancel_o <= 1'b0;
                        moved <= 32'h0;
                        run_o <= 1'b1;
                        torque_limit_o <= (shift_ref_sel == 3'd5)
                            ? stopper[22:16] : 7'h64;
                        speed_o <= speeds[15:0];
                        if (pretrav != 32'h0) begin
                            dir_reverse_o <= ~start_rev;
                            state <= homseq_pkg::HS_PRETRAVEL;
                        end else begin
                            dir_reverse_o <= start_rev;
                            state <= homseq_pkg::HS_SEARCH;
                        end
                    end
                end
                homseq_pkg::HS_PRETRAVEL: begin
                    if (any_ref) begin
                        dir_reverse_o <= home_rev;
                        speed_o <= speeds[31:16];
                        state <= homseq_pkg::HS_CREEP;
                    end else if (moved >= pretrav) begin
                        dir_reverse_o <= start_rev;
                        state <= homseq_pkg::HS_SEARCH;
                    end
                end
                homseq_pkg::HS_SEARCH: begin
                    if (ot_fault) begin
                        timer <= 32'h0;
                        state <= homseq_pkg::HS_OT_DECEL;
                    end else if (shift_hit && creep_reverse_en) begin
                        dir_reverse_o <= ~home_rev;
                        state <= homseq_pkg::HS_BACKUP;
                    end else if (decel_hit || shift_hit) begin
                        dir_reverse_o <= home_rev;
                        speed_o <= speeds[31:16];
                        state <= homseq_pkg::HS_CREEP;
                    end
                end
                homseq_pkg::HS_OT_DECEL: begin
                    speed_o <= 16'h0;
                    if (ot_action_sel) begin
                        torque_limit_o <= third_tl[6:0];
                        run_o <= 1'b0;
                        homing_cancel_o <= 1'b1;
                        state <= homseq_pkg::HS_CANCEL;
                    end else if (timer >= decel_cyc || decel_cyc == 0) begin
                        dir_reverse_o <= ~dir_reverse_o;
                        speed_o <= speeds[15:0];
                        state <= homseq_pkg::HS_SEARCH;
                    end
                end
                homseq_pkg::HS_BACKUP: begin
                    if (!shift_hit && !sw_valid) begin
                        dir_reverse_o <= home_rev;
                        speed_o <= speeds[31:16];
                        state <= homseq_pkg::HS_CREEP;
                    end
                end
                homseq_pkg::HS_CREEP: begin
                    if (index_mode) begin
                        state <= homseq_pkg::HS_WAIT_INDEX;
                    end else if (shift_hit) begin
                        moved <= 32'h0;
                        state <= homseq_pkg::HS_SHIFT;
                    end
                end
                homseq_pkg::HS_WAIT_INDEX: begin
                    if (idx_rise) begin
                        moved <= 32'h0;
                        state <= homseq_pkg::HS_SHIFT;
                    end
                end
                homseq_pkg::HS_SHIFT: begin
                    if (moved >= shift_amt) begin
                        run_o <= 1'b0;
                        position <= coord;
                        homed <= 1'b1;
                        state <= homseq_pkg::HS_DONE;
                    end
                end
            endcase
            if (ot_fault)
                state <= homseq_pkg::HS_OT_DECEL;
        end
    end
    // Completion output gated by detection range
    always_ff @(posedge clk_i) begin
        if (rst_i)
            homing_complete_o <= 1'b0;
        else if (ce_i)
            homing_complete_o <= homed && in_range;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held too long");
    start_pretravel_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_IDLE && start_rise
        && ce_i && pretrav != 0 && !int_active
        |=> state == homseq_pkg::HS_PRETRAVEL)
        else $error("pretravel not entered");
    pretrav_ref_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_PRETRAVEL && ce_i
        && any_ref && !ot_fault |=> state == homseq_pkg::HS_CREEP)
        else $error("ref during pretravel ignored");
    shift_done_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_SHIFT && ce_i
        && moved >= shift_amt |=> position == $past(coord) && homed)
        else $error("completion coordinate not loaded");
    cancel_stop_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_OT_DECEL && ce_i
        && ot_action_sel |=> !run_o && homing_cancel_o)
        else $error("overtravel cancel failed");
    complete_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i) homing_complete_o |-> $past(homed))
        else $error("complete without homing");
    index_wait_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_WAIT_INDEX && ce_i
        && !idx_rise && !ot_fault |=> state == homseq_pkg::HS_WAIT_INDEX)
        else $error("shift began without index");
    busy_ignore_a: assert property (@(posedge clk_i)
        disable iff (rst_i) state == homseq_pkg::HS_SHIFT && start_rise && ce_i
        && moved < shift_amt && !ot_fault |=> state == homseq_pkg::HS_SHIFT)
        else $error("restart during sequence");
    cover_done_c: cover property (@(posedge clk_i)
        state == homseq_pkg::HS_DONE);
    cover_cancel_c: cover property (@(posedge clk_i)
        state == homseq_pkg::HS_CANCEL);
    cover_backup_c: cover property (@(posedge clk_i)
        state == homseq_pkg::HS_BACKUP);
endmodule

// >>> src/homseq_pkg.sv
// Homing sequencer types shared by the design.
// Assumes homseq_regs.svh carries the numeric constants.
package homseq_pkg;

    // Sequencer phases
    typedef enum logic [3:0] {
        HS_IDLE, HS_PRETRAVEL, HS_SEARCH, HS_CREEP, HS_BACKUP,
        HS_WAIT_INDEX, HS_SHIFT, HS_OT_DECEL, HS_DONE, HS_CANCEL
    } homseq_state_type;

    // Shift reference select codes
    typedef enum logic [2:0] {
        HS_REF_SWITCH, HS_REF_INDEX, HS_REF_POT, HS_REF_NOT,
        HS_REF_EXT, HS_REF_STOPPER
    } homseq_ref_type;

endpackage

// >>> src/homseq_regs.svh
// Homing sequencer register map, field layout and reset values.
// Assumes inclusion by bare name from the design.
`ifndef HOMSEQ_REGS_SVH
`define HOMSEQ_REGS_SVH

// ----------------------------------------------------------------
// Register word offsets (byte addresses)
// ----------------------------------------------------------------
`define HS_CTRL_OFF 8'h00
`define HS_CFG_OFF 8'h04
`define HS_PRETRAV_OFF 8'h08
`define HS_SHIFT_OFF 8'h0C
`define HS_COORD_OFF 8'h10
`define HS_RANGE_OFF 8'h14
`define HS_PRESET_OFF 8'h18
`define HS_INTAMT_OFF 8'h1C
`define HS_DECEL_OFF 8'h20
`define HS_STOPPER_OFF 8'h24
`define HS_STATUS_OFF 8'h28
`define HS_POS_OFF 8'h2C
`define HS_SPEED_OFF 8'h30

// ----------------------------------------------------------------
// Configuration register field positions
// ----------------------------------------------------------------
`define HS_CFG_START_DIR 1:0
`define HS_CFG_HOME_DIR 2
`define HS_CFG_SHIFT_REF 6:4
`define HS_CFG_DECEL_REF 9:8
`define HS_CFG_EDGE 12
`define HS_CFG_CREEP_REV 13
`define HS_CFG_OT_ACT 14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HS_CFG_RST 32'h0000_0010
`define HS_SHIFT_RST 32'h0000_03E8
`define HS_INTAMT_RST 32'h0001_86A0
`define HS_DECEL_RST 32'h0000_03E8
`define HS_HOMING_SPD_RST 16'hC350
`define HS_CREEP_SPD_RST 16'h1388

// ----------------------------------------------------------------
// Timing: clock rate and stopper time unit
// ----------------------------------------------------------------
`define HS_CLK_HZ 50000000
`define HS_MS_CYCLES (`HS_CLK_HZ / 1000)

`endif

// >>> tb/homing_sequencer_tb_top.sv
// Self-checking bench for the homing sequencer core.
// Assumes the field model moves as the sequencer commands.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    failures++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
    end end
module homing_sequencer_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rd, rdat;
    logic start = 1'b0, pot = 1'b0, preset = 1'b0, ext = 1'b0;
    logic ack, run, rev, step, sdir, sw, idx, done, cancel;
    logic [15:0] spd;
    int failures = 0, num_checks = 0;
    homseq_core homseq_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .homing_start_cmd_i(start), .home_limit_switch_i(sw),
        .positive_overtravel_i(pot), .negative_overtravel_i(1'b0),
        .index_pulse_i(idx), .external_input_i(ext),
        .preset_cmd_i(preset), .pos_step_i(step), .pos_dir_i(sdir),
        .torque_at_limit_i(1'b0), .run_o(run), .dir_reverse_o(rev),
        .speed_o(spd), .torque_limit_o(), .homing_complete_o(done),
        .homing_cancel_o(cancel));
    homseq_field_model field (.clk_i(clk_i), .run_i(run),
        .dir_reverse_i(rev), .pos_step_o(step), .pos_dir_o(sdir),
        .home_switch_o(sw), .index_pulse_o(idx));
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watched level by number: 0 switch, 1 run, other cancel
    function automatic logic pick(input int which);
        case (which)
            0: return sw;
            1: return run;
            default: return cancel;
        endcase
    endfunction
    // Bounded wait for a level; a hang ends the run as a failure
    task automatic wait_for(input int which, input logic v, input int n);
        int k;
        k = 0;
        while (pick(which) !== v) begin
            @(negedge clk_i);
            k++;
            if (k > n) begin
                failures++;
                wrap_up();
            end
        end
    endtask
    // Classic cycle, held until ack is sampled high at a rising edge;
    // read data is taken at that same edge, then the request drops
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
            if (k > 20) begin
                failures++;
                wrap_up();
            end
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Long enough for the pin synchroniser to see both edges
    // Pin by number: 0 start, 1 preset, other external input
    task automatic pulse(input int which);
        @(posedge clk_i);
        case (which)
            0: start <= 1'b1;
            1: preset <= 1'b1;
            default: ext <= 1'b1;
        endcase
        repeat (4) @(posedge clk_i);
        case (which)
            0: start <= 1'b0;
            1: preset <= 1'b0;
            default: ext <= 1'b0;
        endcase
        repeat (6) @(posedge clk_i);
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic t_defaults();
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_0010)
        bus(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h0000_03E8)
        bus(1'b0, 8'h1C, 32'h0);
        `CHK(rd, 32'h0001_86A0)
        bus(1'b0, 8'h30, 32'h0);
        `CHK(rd, 32'h1388_C350)
        bus(1'b0, 8'hFC, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    task automatic t_preset();
        bus(1'b1, 8'h18, 32'hFFFF_FF85);
        pulse(1);
        bus(1'b0, 8'h2C, 32'h0);
        `CHK(rd, 32'hFFFF_FF85)
    endtask
    // Switch at 12 slows to creep, index at 16, shift of 5 ends at 21
    task automatic t_home();
        bus(1'b1, 8'h0C, 32'h5);
        bus(1'b1, 8'h10, 32'h0000_0123);
        pulse(0);
        `CHK(run, 1'b1)
        `CHK(rev, 1'b0)
        `CHK(spd, 16'hC350)
        wait_for(0, 1'b1, 600);
        repeat (8) @(negedge clk_i);
        `CHK(spd, 16'h1388)
        wait_for(1, 1'b0, 600);
        repeat (2) @(negedge clk_i);
        `CHK(done, 1'b1)
        `CHK(field.pos, 21)
        bus(1'b0, 8'h2C, 32'h0);
        `CHK(rd, 32'h0000_0123)
    endtask
    // Stop action chosen, then applied by a reset
    task automatic t_ot_stop();
        bus(1'b1, 8'h04, 32'h0000_4010);
        do_reset();
        pulse(0);
        `CHK(cancel, 1'b0)
        @(posedge clk_i);
        pot <= 1'b1;
        wait_for(2, 1'b1, 50);
        `CHK(run, 1'b0)
        @(posedge clk_i);
        pot <= 1'b0;
    endtask
    // Interrupt input turn-on starts a move of exactly the set amount
    task automatic t_interrupt();
        int p0;
        bus(1'b1, 8'h1C, 32'h0000_0003);
        p0 = field.pos;
        pulse(2);
        `CHK(run, 1'b1)
        wait_for(1, 1'b0, 200);
        repeat (4) @(negedge clk_i);
        `CHK(field.pos - p0, 3)
    endtask
    initial begin
        do_reset();
        t_defaults();
        t_preset();
        t_home();
        t_ot_stop();
        t_interrupt();
        wrap_up();
    end
endmodule

// >>> tb/homseq_field_model.sv
// Far side of the sequencer: encoder counts, index and home switch.
// Assumes run and direction come straight from the sequencer.
`timescale 1ns/100ps
module homseq_field_model #(
    parameter int SW_AT = 12
) (
    // Clock
    input wire logic clk_i,
    // Motion command
    input wire logic run_i,
    input wire logic dir_reverse_i,
    // Encoder and switch lines
    output logic pos_step_o,
    output logic pos_dir_o,
    output logic home_switch_o,
    output logic index_pulse_o
);
    int pos = 0;
    logic [2:0] ph = 3'h0;
    // One count per eight cycles, slow enough to stop on a count
    always_ff @(posedge clk_i) begin
        ph <= run_i ? ph + 3'h1 : 3'h0;
        if (run_i && ph == 3'h3) begin
            pos <= dir_reverse_i ? pos - 1 : pos + 1;
        end
    end
    // Switch and index are fixed marks on the axis
    assign pos_step_o = ph[2];
    assign pos_dir_o = dir_reverse_i;
    assign home_switch_o = pos >= SW_AT;
    assign index_pulse_o = pos[2:0] == 3'h0;
endmodule
